// File: logic/chan_status_regs.vh
`ifndef CHAN_STATUS_REGS_VH
`define CHAN_STATUS_REGS_VH

// global status words, engine a / engine b (engine b = engine a + 4)
`define CIS_A_ADDR        12'h200
`define CIS_B_ADDR        12'h204
`define CDTRS_A_ADDR      12'h210
`define CDTRS_B_ADDR      12'h214
`define CIOS_A_ADDR       12'h220
`define CIOS_B_ADDR       12'h224
`define CDTROS_A_ADDR     12'h230
`define CDTROS_B_ADDR     12'h234
`define TB_SHARE_ADDR     12'h00c
`define TB_SHARE_RESET    32'h00000000
// time base share control field positions
`define TB_SHARE_EN_BIT   16
`define TB_SHARE_SRV_BIT  17
`define TB_ANGLE_MODE_BIT 6

// channel register structures
`define CHAN_A_BASE       12'h400
`define CHAN_B_BASE       12'h800
`define CHAN_STRIDE       12'h010
`define CHAN_CFG_OFS      4'h0
`define CHAN_SCR_OFS      4'h4
`define CHAN_HSR_OFS      4'h8
// status/control bit positions
`define SCR_IRQ_BIT       31
`define SCR_IOVF_BIT      30
`define SCR_XFER_BIT      23
`define SCR_XOVF_BIT      22

// channels wired to the dma controller
`define DMA_MAP_A         32'h3000f007
`define DMA_MAP_B         32'hf000f00f
`define FLAGS_RESET       32'h00000000

`endif

// File: logic/channel_request_status_aggregator.v
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`include "chan_status_regs.vh"

// What this block does
// - channel structures every 16 bytes, 0x400/0x800
// - structure holds config, status/control, host service
// - global and per-channel views share storage
// - interrupt status reads pending per channel
// - write one clears interrupt status bit
// - transfer request status reads pending per channel
// - write one clears transfer request bit
// - only listed channels drive dma lines
// - unconnected channels raise no dma request; interrupt lines are not masked
// - unconnected channels still set and clear status
// - interrupt on set flag sets overflow
// - interrupt overflow reads, write one clears
// - transfer overflow reads per channel
// - write one clears transfer overflow bit
// - time base two client disables angle clock
module channel_request_status_aggregator #(
  parameter NCH = 32
) (
  // clock and reset
  input  wire            i_core_clk,
  input  wire            i_rst_n,
  // register port
  input  wire [11:0]     i_addr,
  input  wire [31:0]     i_wdata,
  input  wire            i_wr,
  input  wire            i_rd,
  output reg  [31:0]     o_rdata,
  // channel events from the engines
  input  wire [NCH-1:0]  i_irq_raise_a,
  input  wire [NCH-1:0]  i_irq_raise_b,
  input  wire [NCH-1:0]  i_xfer_raise_a,
  input  wire [NCH-1:0]  i_xfer_raise_b,
  // outputs to interrupt and dma controllers
  output wire [NCH-1:0]  o_irq_a,
  output wire [NCH-1:0]  o_irq_b,
  output wire [NCH-1:0]  o_dma_req_a,
  output wire [NCH-1:0]  o_dma_req_b,
  // time base control
  output wire            o_angle_clock_en,
  // per-channel config words of engine a, held here for the channel logic
  output wire [NCH*32-1:0] o_chan_cfg_flat
);

  // decode
  wire        in_a   = (i_addr >= `CHAN_A_BASE) && (i_addr < (`CHAN_A_BASE + 12'h200));
  wire        in_b   = (i_addr >= `CHAN_B_BASE) && (i_addr < (`CHAN_B_BASE + 12'h200));
  wire [4:0]  ch_idx = i_addr[8:4];
  wire [3:0]  ch_ofs = i_addr[3:0];
  wire        scr_hit = ch_ofs == `CHAN_SCR_OFS;
  wire        wr_scr_a = i_wr && in_a && scr_hit;
  wire        wr_scr_b = i_wr && in_b && scr_hit;
  wire [31:0] ch_bit  = 32'h00000001 << ch_idx;

  // write-one-to-clear masks; global and per-channel writes target the same flags
  reg  [31:0] clr_irq_a;
  reg  [31:0] clr_irq_b;
  reg  [31:0] clr_xf_a;
  reg  [31:0] clr_xf_b;
  reg  [31:0] clr_io_a;
  reg  [31:0] clr_io_b;
  reg  [31:0] clr_xo_a;
  reg  [31:0] clr_xo_b;

  always @* begin
    clr_irq_a = 32'h00000000;
    clr_irq_b = 32'h00000000;
    clr_xf_a  = 32'h00000000;
    clr_xf_b  = 32'h00000000;
    clr_io_a  = 32'h00000000;
    clr_io_b  = 32'h00000000;
    clr_xo_a  = 32'h00000000;
    clr_xo_b  = 32'h00000000;
    // a global word write clears every channel whose bit is written with one
    if (i_wr) begin
      case (i_addr)
        `CIS_A_ADDR:    clr_irq_a = i_wdata;
        `CIS_B_ADDR:    clr_irq_b = i_wdata;
        `CDTRS_A_ADDR:  clr_xf_a  = i_wdata;
        `CDTRS_B_ADDR:  clr_xf_b  = i_wdata;
        `CIOS_A_ADDR:   clr_io_a  = i_wdata;
        `CIOS_B_ADDR:   clr_io_b  = i_wdata;
        `CDTROS_A_ADDR: clr_xo_a  = i_wdata;
        `CDTROS_B_ADDR: clr_xo_b  = i_wdata;
        default:        clr_irq_a = 32'h00000000;
      endcase
    end
    // a status/control write clears only the addressed channel
    if (wr_scr_a) begin
      if (i_wdata[`SCR_IRQ_BIT]) begin
        clr_irq_a = ch_bit;
      end
      if (i_wdata[`SCR_IOVF_BIT]) begin
        clr_io_a = ch_bit;
      end
      if (i_wdata[`SCR_XFER_BIT]) begin
        clr_xf_a = ch_bit;
      end
      if (i_wdata[`SCR_XOVF_BIT]) begin
        clr_xo_a = ch_bit;
      end
    end
    // engine b structures
    if (wr_scr_b) begin
      if (i_wdata[`SCR_IRQ_BIT]) begin
        clr_irq_b = ch_bit;
      end
      if (i_wdata[`SCR_IOVF_BIT]) begin
        clr_io_b = ch_bit;
      end
      if (i_wdata[`SCR_XFER_BIT]) begin
        clr_xf_b = ch_bit;
      end
      if (i_wdata[`SCR_XOVF_BIT]) begin
        clr_xo_b = ch_bit;
      end
    end
  end

  // flag banks: [0]=irq a, [1]=irq b, [2]=xfer a, [3]=xfer b
  wire [31:0] pend [0:3];
  wire [31:0] ovf_ev [0:3];
  wire [31:0] ovf [0:3];

  w1c_flag_bank #(.WIDTH(32)) u_irq_a (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_set      (i_irq_raise_a),
    .i_clr      (clr_irq_a),
    .o_flags    (pend[0]),
    .o_overflow (ovf_ev[0])
  );
  w1c_flag_bank #(.WIDTH(32)) u_irq_b (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_set      (i_irq_raise_b),
    .i_clr      (clr_irq_b),
    .o_flags    (pend[1]),
    .o_overflow (ovf_ev[1])
  );
  w1c_flag_bank #(.WIDTH(32)) u_xf_a (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_set      (i_xfer_raise_a),
    .i_clr      (clr_xf_a),
    .o_flags    (pend[2]),
    .o_overflow (ovf_ev[2])
  );
  w1c_flag_bank #(.WIDTH(32)) u_xf_b (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_set      (i_xfer_raise_b),
    .i_clr      (clr_xf_b),
    .o_flags    (pend[3]),
    .o_overflow (ovf_ev[3])
  );

  // overflow banks take the overflow events as their set
  w1c_flag_bank #(.WIDTH(32)) u_io_a (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_set      (ovf_ev[0]),
    .i_clr      (clr_io_a),
    .o_flags    (ovf[0]),
    .o_overflow ()
  );
  w1c_flag_bank #(.WIDTH(32)) u_io_b (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_set      (ovf_ev[1]),
    .i_clr      (clr_io_b),
    .o_flags    (ovf[1]),
    .o_overflow ()
  );
  w1c_flag_bank #(.WIDTH(32)) u_xo_a (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_set      (ovf_ev[2]),
    .i_clr      (clr_xo_a),
    .o_flags    (ovf[2]),
    .o_overflow ()
  );
  w1c_flag_bank #(.WIDTH(32)) u_xo_b (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_set      (ovf_ev[3]),
    .i_clr      (clr_xo_b),
    .o_flags    (ovf[3]),
    .o_overflow ()
  );

  // dma requests reach the controller only where wired; interrupts pass unmasked
  assign o_irq_a     = pend[0];
  assign o_irq_b     = pend[1];
  assign o_dma_req_a = pend[2] & `DMA_MAP_A;
  assign o_dma_req_b = pend[3] & `DMA_MAP_B;

  // time base sharing control
  reg  [31:0] tb_share_q;
  wire        tb2_client = tb_share_q[`TB_SHARE_EN_BIT] && !tb_share_q[`TB_SHARE_SRV_BIT];
  assign o_angle_clock_en = tb_share_q[`TB_ANGLE_MODE_BIT] && !tb2_client;

  // per-channel config and host service words, 64 channels each
  reg  [31:0] cfg_q [0:63];
  reg  [31:0] hsr_q [0:63];
  // engine select forms the top bit of the word index
  wire [5:0]  widx = {in_b, ch_idx};
  integer     k;

  // share control and per-channel words; reserved offset 0xc is not stored
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tb_share_q <= `TB_SHARE_RESET;
      for (k = 0; k < 64; k = k + 1) begin
        cfg_q[k] <= 32'h00000000;
        hsr_q[k] <= 32'h00000000;
      end
    end else begin
      if (i_wr && i_addr == `TB_SHARE_ADDR) begin
        tb_share_q <= i_wdata;
      end
      if (i_wr && (in_a || in_b) && ch_ofs == `CHAN_CFG_OFS) begin
        cfg_q[widx] <= i_wdata;
      end
      if (i_wr && (in_a || in_b) && ch_ofs == `CHAN_HSR_OFS) begin
        hsr_q[widx] <= i_wdata;
      end
    end
  end

  // engine a configuration words go out to the channel logic
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_cfg
      assign o_chan_cfg_flat[g*32 +: 32] = cfg_q[g];
    end
  endgenerate

  // per-channel status/control view built from the shared flags
  reg  [3:0]  scr_bits;
  reg  [31:0] scr_word;
  reg  [31:0] rd_d;

  always @* begin
    if (in_b) begin
      scr_bits[3] = pend[1][ch_idx];
      scr_bits[2] = ovf[1][ch_idx];
      scr_bits[1] = pend[3][ch_idx];
      scr_bits[0] = ovf[3][ch_idx];
    end else begin
      scr_bits[3] = pend[0][ch_idx];
      scr_bits[2] = ovf[0][ch_idx];
      scr_bits[1] = pend[2][ch_idx];
      scr_bits[0] = ovf[2][ch_idx];
    end
  end

  always @* begin
    scr_word = 32'h00000000;
    scr_word[`SCR_IRQ_BIT]  = scr_bits[3];
    scr_word[`SCR_IOVF_BIT] = scr_bits[2];
    scr_word[`SCR_XFER_BIT] = scr_bits[1];
    scr_word[`SCR_XOVF_BIT] = scr_bits[0];
    // unmapped and reserved addresses read zero
    rd_d = 32'h00000000;
    if (in_a || in_b) begin
      case (ch_ofs)
        `CHAN_CFG_OFS: rd_d = cfg_q[widx];
        `CHAN_SCR_OFS: rd_d = scr_word;
        `CHAN_HSR_OFS: rd_d = hsr_q[widx];
        default:       rd_d = 32'h00000000;
      endcase
    end else begin
      case (i_addr)
        `CIS_A_ADDR:    rd_d = pend[0];
        `CIS_B_ADDR:    rd_d = pend[1];
        `CDTRS_A_ADDR:  rd_d = pend[2];
        `CDTRS_B_ADDR:  rd_d = pend[3];
        `CIOS_A_ADDR:   rd_d = ovf[0];
        `CIOS_B_ADDR:   rd_d = ovf[1];
        `CDTROS_A_ADDR: rd_d = ovf[2];
        `CDTROS_B_ADDR: rd_d = ovf[3];
        `TB_SHARE_ADDR: rd_d = tb_share_q;
        default:        rd_d = 32'h00000000;
      endcase
    end
  end

  // read data stand for one cycle after the strobe, zero otherwise
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      o_rdata <= rd_d;
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule // channel_request_status_aggregator

// File: logic/w1c_flag_bank.v
`timescale 1ns/10ps
// one 32-bit bank of sticky flags with write-one-to-clear; set wins over clear
module w1c_flag_bank #(
  parameter WIDTH = 32
) (
  // clock and reset
  input  wire             i_core_clk,
  input  wire             i_rst_n,
  // set and clear
  input  wire [WIDTH-1:0] i_set,
  input  wire [WIDTH-1:0] i_clr,
  // state
  output wire [WIDTH-1:0] o_flags,
  output wire [WIDTH-1:0] o_overflow
);

  reg [WIDTH-1:0] flag_q;
  wire [WIDTH-1:0] flag_d;
  wire [WIDTH-1:0] ovf_d;

  assign flag_d = (flag_q & ~i_clr) | i_set;
  // a new event on a still-set flag counts as an overflow
  assign ovf_d  = i_set & flag_q;

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      flag_q <= {WIDTH{1'b0}};
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flags    = flag_q;
  assign o_overflow = ovf_d;

endmodule // w1c_flag_bank

// File: tb/chan_event_engine.sv
`timescale 1ns/10ps
// engine side: sparse random raise pulses while running
module chan_event_engine (
  // clock and control
  input  wire        i_core_clk,
  input  wire        i_run,
  // raise pulses
  output reg  [31:0] o_irq_a = 32'h0,
  output reg  [31:0] o_irq_b = 32'h0,
  output reg  [31:0] o_xfer_a = 32'h0,
  output reg  [31:0] o_xfer_b = 32'h0
);
  integer seed = 26725;
  always @(posedge i_core_clk) begin
    o_irq_a  <= i_run ? $random(seed) & $random(seed) & $random(seed) : 32'h0;
    o_irq_b  <= i_run ? $random(seed) & $random(seed) & $random(seed) : 32'h0;
    o_xfer_a <= i_run ? $random(seed) & $random(seed) & $random(seed) : 32'h0;
    o_xfer_b <= i_run ? $random(seed) & $random(seed) & $random(seed) : 32'h0;
  end
endmodule // chan_event_engine

// File: tb/channel_request_status_aggregator_tb_top.sv
`timescale 1ns/10ps
`include "chan_status_regs.vh"
module channel_request_status_aggregator_tb_top;
  logic          i_core_clk = 1'b0;
  logic          i_rst_n = 1'b0;
  logic [11:0]   i_addr = 12'h000;
  logic [31:0]   i_wdata = 32'h0;
  logic          i_wr = 1'b0;
  logic          i_rd = 1'b0;
  logic          run = 1'b0;
  logic [31:0]   o_rdata, o_irq_a, o_irq_b, o_dma_req_a, o_dma_req_b, ira, irb, xra, xrb;
  logic          o_angle_clock_en;
  logic [1023:0] o_chan_cfg_flat;
  logic [31:0]   m [8];
  logic [31:0]   clr [8];
  logic [31:0]   r [4];
  logic [31:0]   mem [int];
  logic [31:0]   exp_d, exp_m, v;
  logic [11:0]   a;
  logic          rd_q = 1'b0;
  integer        err_count = 0, num_checks = 0, seed = 26725, i, j, e, c, x, rc, rx, rj;
  always #10 i_core_clk = ~i_core_clk;
  channel_request_status_aggregator channel_request_status_aggregator_i (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_raise_a(ira), .i_irq_raise_b(irb), .i_xfer_raise_a(xra),
    .i_xfer_raise_b(xrb), .o_irq_a(o_irq_a), .o_irq_b(o_irq_b), .o_dma_req_a(o_dma_req_a),
    .o_dma_req_b(o_dma_req_b), .o_angle_clock_en(o_angle_clock_en), .o_chan_cfg_flat(o_chan_cfg_flat));
  chan_event_engine chan_event_engine_i (.i_core_clk(i_core_clk), .i_run(run), .o_irq_a(ira),
    .o_irq_b(irb), .o_xfer_a(xra), .o_xfer_b(xrb));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task complete_run;
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task bus(input logic w, input logic rd, input logic [11:0] ad, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr <= w;
    i_rd <= rd;
    i_addr <= ad;
    i_wdata <= d;
  endtask
  // reference model of every flag word, updated from the port values before each edge
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      for (j = 0; j < 8; j++) m[j] = 32'h0;
      rd_q = 1'b0;
    end else begin
      check(o_irq_a, m[0]);
      check(o_irq_b, m[1]);
      check(o_dma_req_a, m[2] & `DMA_MAP_A);
      check(o_dma_req_b, m[3] & `DMA_MAP_B);
      if (rd_q) check(o_rdata & exp_m, exp_d);
      rd_q = i_rd;
      exp_m = 32'hffffffff;
      exp_d = 32'h0;
      for (j = 0; j < 8; j++) clr[j] = 32'h0;
      x = {i_addr[5:4], i_addr[2]};
      e = i_addr[11];
      c = i_addr[8:4];
      if (i_addr[11:6] == 6'h08 && !i_addr[3]) begin
        exp_d = m[x];
        if (i_wr) clr[x] = i_wdata;
      end else if ((i_addr[11:9] == 3'b010 || i_addr[11:9] == 3'b100) && i_addr[3:0] == 4'h4) begin
        exp_m = 32'hc0c00000;
        exp_d = {m[e][c], m[4+e][c], 6'h0, m[2+e][c], m[6+e][c], 22'h0};
        if (i_wr) {clr[e][c], clr[4+e][c], clr[2+e][c], clr[6+e][c]} = {i_wdata[31:30], i_wdata[23:22]};
      end else if (i_addr[11:9] == 3'b010 || i_addr[11:9] == 3'b100) begin
        if (i_addr[3:0] != 4'hc && mem.exists(i_addr)) exp_d = mem[i_addr];
        if (i_wr && i_addr[3:0] != 4'hc) mem[i_addr] = i_wdata;
      end
      r = '{ira, irb, xra, xrb};
      for (j = 0; j < 4; j++) begin
        m[j+4] = (m[j+4] & ~clr[j+4]) | (r[j] & m[j]);
        m[j] = (m[j] & ~clr[j]) | r[j];
      end
    end
  end
  initial begin
    #2000000;
    err_count++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (i = 0; i < 8; i++) bus(1'b0, 1'b1, {6'h08, i[2:1], 1'b0, i[0], 2'b00}, 32'h0);
    foreach (r[i]) begin
      v = (i == 0) ? 32'h40 : (i == 1) ? 32'h10040 : (i == 2) ? 32'h30040 : 32'h10000;
      bus(1'b1, 1'b0, 12'h00c, v);
      bus(1'b0, 1'b0, 12'h000, 32'h0);
      #1 check({31'h0, o_angle_clock_en}, {31'h0, i < 3 && i != 1});
    end
    run <= 1'b1;
    repeat (3000) begin
      rc = {$random(seed)} % 32;
      rx = {$random(seed)} % 8;
      a = {($random(seed) & 1) ? 2'b10 : 2'b01, 1'b0, rc[4:0], 4'h0};
      case ({$random(seed)} % 6)
        0: a = {6'h08, rx[2:1], 1'b0, rx[0], 2'b00};
        1: a = a + 12'h004;
        2: a = a;
        3: a = a + 12'h008;
        4: a = a + 12'h00c;
        default: a = 12'h600;
      endcase
      rj = $random(seed) & 1;
      bus(rj[0], !rj[0], a, $random(seed));
    end
    run <= 1'b0;
    repeat (3) bus(1'b0, 1'b0, 12'h000, 32'h0);
    for (i = 0; i < 32; i++) check(o_chan_cfg_flat[i*32 +: 32], mem.exists(1024 + 16 * i) ? mem[1024 + 16 * i] : 32'h0);
    complete_run;
  end
endmodule // channel_request_status_aggregator_tb_top
bind channel_request_status_aggregator crsa_sva #(.NCH(NCH)) crsa_sva_i (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_irq_raise_a(i_irq_raise_a), .i_irq_raise_b(i_irq_raise_b), .i_xfer_raise_b(i_xfer_raise_b),
  .o_irq_a(o_irq_a), .o_irq_b(o_irq_b), .o_dma_req_a(o_dma_req_a), .o_dma_req_b(o_dma_req_b),
  .o_angle_clock_en(o_angle_clock_en));

// File: tb/crsa_sva.sv
`timescale 1ns/10ps
`include "chan_status_regs.vh"
module crsa_sva #(
  parameter NCH = 32
) (
  input wire           i_core_clk,
  input wire           i_rst_n,
  input wire [11:0]    i_addr,
  input wire [31:0]    i_wdata,
  input wire           i_wr,
  input wire           i_rd,
  input wire [31:0]    o_rdata,
  input wire [NCH-1:0] i_irq_raise_a,
  input wire [NCH-1:0] i_irq_raise_b,
  input wire [NCH-1:0] i_xfer_raise_b,
  input wire [NCH-1:0] o_irq_a,
  input wire [NCH-1:0] o_irq_b,
  input wire [NCH-1:0] o_dma_req_a,
  input wire [NCH-1:0] o_dma_req_b,
  input wire           o_angle_clock_en
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  property p_irq_set;
    (|i_irq_raise_a) |=> ((o_irq_a & $past(i_irq_raise_a)) == $past(i_irq_raise_a));
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq flag not set");
  property p_irq_clr;
    i_wr && i_addr == 12'h204 |=> o_irq_b == (($past(o_irq_b) & ~$past(i_wdata)) | $past(i_irq_raise_b));
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq clear wrong");
  property p_rd_irq;
    i_rd && i_addr == 12'h200 |=> o_rdata == $past(o_irq_a);
  endproperty
  a_rd_irq: assert property (p_rd_irq) else $error("irq word read wrong");
  property p_rd_xfer;
    i_rd && i_addr == 12'h210 |=> (o_rdata & `DMA_MAP_A) == $past(o_dma_req_a);
  endproperty
  a_rd_xfer: assert property (p_rd_xfer) else $error("xfer word read wrong");
  property p_dma_a;
    (o_dma_req_a & ~`DMA_MAP_A) == 32'h0;
  endproperty
  a_dma_a: assert property (p_dma_a) else $error("unwired dma line a");
  property p_dma_b;
    (o_dma_req_b & ~`DMA_MAP_B) == 32'h0;
  endproperty
  a_dma_b: assert property (p_dma_b) else $error("unwired dma line b");
  property p_dma_set;
    (|i_xfer_raise_b) |=> ((o_dma_req_b & $past(i_xfer_raise_b)) == ($past(i_xfer_raise_b) & `DMA_MAP_B));
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("dma request missing");
  property p_rst;
    @(posedge i_core_clk) disable iff (1'b0) !i_rst_n |=> (o_irq_a | o_irq_b | o_dma_req_a | o_dma_req_b) == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("flags not zero after reset");
  property p_angle;
    i_wr && i_addr == 12'h00c |=> o_angle_clock_en == ($past(i_wdata[6]) && !($past(i_wdata[16]) && !$past(i_wdata[17])));
  endproperty
  a_angle: assert property (p_angle) else $error("angle clock enable wrong");
endmodule // crsa_sva
